/* File: include/mbox_host_pkg.sv */
package mbox_host_pkg;

    // device map seen through one port
    localparam int WORD_W = 9;
    localparam int ADDR_W = 9;
    localparam logic [8:0] MBOX_X_ADDR = 9'h000;
    localparam logic [8:0] MBOX_Y_ADDR = 9'h1FF;
    localparam int FLAG_REQ_BIT = 0;
    localparam int FLAG_ENA_BIT = 1;
    localparam int FLAG_ACK_BIT = 2;

    // controller registers on the apb side
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] ADDR_OFF = 12'h004;
    localparam logic [11:0] WDATA_OFF = 12'h008;
    localparam logic [11:0] RDATA_OFF = 12'h00C;
    localparam logic [11:0] STATUS_OFF = 12'h010;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;
    localparam logic [8:0] ADDR_RESET = 9'h000;
    localparam logic [8:0] DATA_RESET = 9'h000;

    // pin timing in ns and the clock period
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_HOLD_NS = 20;
    localparam int OUTPUT_ACCESS_NS = 55;
    localparam int SELECT_ACCESS_NS = 120;
    localparam int SELECT_RECOVERY_NS = 30;
    localparam int WRITE_DATA_SETUP_NS = 40;
    localparam int WRITE_DATA_HOLD_NS = 10;
    localparam int SELECT_TO_WRITE_END_NS = 120;
    localparam int OUTPUT_OFF_TO_FLOAT_NS = 40;
    localparam int SYNC_STAGES = 2;

    // least time in whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam logic [3:0] ADDR_HOLD_CYC = 4'(cyc_min(ADDR_HOLD_NS));
    localparam logic [3:0] READ_WAIT_CYC =
        4'(max2(cyc_min(OUTPUT_ACCESS_NS), cyc_min(SELECT_ACCESS_NS)) + SYNC_STAGES);
    localparam logic [3:0] WRITE_PULSE_CYC =
        4'(max2(cyc_min(SELECT_TO_WRITE_END_NS), cyc_min(WRITE_DATA_SETUP_NS)));
    localparam logic [3:0] WRITE_HOLD_CYC = 4'(cyc_min(WRITE_DATA_HOLD_NS));
    localparam logic [3:0] FLOAT_CYC = 4'(cyc_min(OUTPUT_OFF_TO_FLOAT_NS));
    localparam logic [3:0] RECOVERY_CYC = 4'(cyc_min(SELECT_RECOVERY_NS));

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_RMW,
        OP_SPARE
    } op_t;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_HOLD,
        ST_TURN,
        ST_ACCESS,
        ST_RMW_FLOAT,
        ST_WPULSE,
        ST_WHOLD,
        ST_RECOVER
    } state_t;

endpackage

/* File: hw/sync_two_stage.sv */
`timescale 1ns/1ps
// two flip-flop synchroniser for pin inputs
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= INIT;
            stable_reg <= INIT;
        end else begin
            meta_reg <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;
endmodule

/* File: hw/mbox_host.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// apb-controlled master for one port of the dual-port mailbox memory
module mbox_host
    import mbox_host_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [8:0] ad_in,
    output logic [8:0] ad_out,
    output logic ad_oe,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    input wire logic int_n
);
    state_t state_reg;
    op_t op_reg;
    logic [3:0] cnt_reg;
    logic [8:0] addr_reg;
    logic [8:0] wdata_reg;
    logic [8:0] rdata_reg;
    logic busy_reg;
    logic done_reg;
    logic go_reg;
    op_t go_op_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [8:0] ad_out_reg;
    logic ad_oe_reg;
    logic ce_n_reg;
    logic oe_n_reg;
    logic we_n_reg;
    logic [8:0] ad_sync;
    logic int_sync_n;
    logic apb_fire;
    logic apb_wr;
    logic mapped;
    logic last_cyc;
    logic fin_pulse;

    // pin inputs cross into pclk through two flops
    sync_two_stage #(.WIDTH(WORD_W), .INIT(9'h000)) u_ad_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ad_in),
        .sync_out(ad_sync)
    );

    sync_two_stage #(.WIDTH(1), .INIT(1'b1)) u_int_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(int_n),
        .sync_out(int_sync_n)
    );

    // apb access completes in the second access cycle
    assign apb_fire = psel && penable && pready_reg;
    assign apb_wr = apb_fire && pwrite;
    assign mapped = (paddr == CTRL_OFF) || (paddr == ADDR_OFF) || (paddr == WDATA_OFF)
        || (paddr == RDATA_OFF) || (paddr == STATUS_OFF);
    assign last_cyc = (cnt_reg == 4'h1);
    assign fin_pulse = (state_reg == ST_RECOVER) && last_cyc;

    // apb ready and read data, both registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            prdata_reg <= 32'h0000_0000;
            if (psel && penable && !pready_reg && !pwrite) begin
                case (paddr)
                    ADDR_OFF: prdata_reg <= {23'h000000, addr_reg};
                    WDATA_OFF: prdata_reg <= {23'h000000, wdata_reg};
                    RDATA_OFF: prdata_reg <= {23'h000000, rdata_reg};
                    STATUS_OFF: begin
                        prdata_reg[STAT_BUSY_BIT] <= busy_reg;
                        prdata_reg[STAT_DONE_BIT] <= done_reg;
                        prdata_reg[STAT_IRQ_BIT] <= !int_sync_n;
                    end
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // address and write data registers; frozen while a cycle runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= ADDR_RESET;
            wdata_reg <= DATA_RESET;
        end else if (apb_wr && !busy_reg) begin
            if (paddr == ADDR_OFF) begin
                addr_reg <= pwdata[8:0];
            end
            if (paddr == WDATA_OFF) begin
                wdata_reg <= pwdata[8:0];
            end
        end
    end

    // start request; ignored while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_reg <= 1'b0;
            go_op_reg <= OP_READ;
        end else begin
            go_reg <= apb_wr && !busy_reg && !go_reg && (paddr == CTRL_OFF)
                && pwdata[CTRL_START_BIT] && (op_t'(pwdata[CTRL_OP_LSB +: 2]) != OP_SPARE);
            go_op_reg <= op_t'(pwdata[CTRL_OP_LSB +: 2]);
        end
    end

    // done flag: completion wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
        end else if (fin_pulse) begin
            done_reg <= 1'b1;
        end else if (apb_wr && (paddr == STATUS_OFF) && pwdata[STAT_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // pin sequencer: one state per phase, counter gives each phase its length except the one-cycle ST_ADDR and ST_TURN
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            rdata_reg <= DATA_RESET;
            ad_out_reg <= 9'h000;
            ad_oe_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
        end else begin
            if (cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (go_reg) begin
                        op_reg <= go_op_reg;
                        busy_reg <= 1'b1;
                        ad_out_reg <= addr_reg;
                        ad_oe_reg <= 1'b1;
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    ce_n_reg <= 1'b0;
                    cnt_reg <= ADDR_HOLD_CYC;
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (last_cyc) begin
                        if (op_reg == OP_WRITE) begin
                            ad_out_reg <= wdata_reg;
                            we_n_reg <= 1'b0;
                            cnt_reg <= WRITE_PULSE_CYC;
                            state_reg <= ST_WPULSE;
                        end else begin
                            ad_oe_reg <= 1'b0; // release before outputs turn on
                            state_reg <= ST_TURN;
                        end
                    end
                end
                ST_TURN: begin
                    oe_n_reg <= 1'b0;
                    cnt_reg <= READ_WAIT_CYC;
                    state_reg <= ST_ACCESS;
                end
                ST_ACCESS: begin
                    if (last_cyc) begin
                        rdata_reg <= ad_sync;
                        oe_n_reg <= 1'b1;
                        cnt_reg <= FLOAT_CYC;
                        if (op_reg == OP_RMW) begin
                            state_reg <= ST_RMW_FLOAT;
                        end else begin
                            ce_n_reg <= 1'b1;
                            cnt_reg <= 4'(max2(FLOAT_CYC, RECOVERY_CYC));
                            state_reg <= ST_RECOVER;
                        end
                    end
                end
                ST_RMW_FLOAT: begin
                    if (last_cyc) begin
                        ad_out_reg <= wdata_reg;
                        ad_oe_reg <= 1'b1;
                        we_n_reg <= 1'b0;
                        cnt_reg <= WRITE_PULSE_CYC;
                        state_reg <= ST_WPULSE;
                    end
                end
                ST_WPULSE: begin
                    if (last_cyc) begin
                        we_n_reg <= 1'b1;
                        ce_n_reg <= 1'b1;
                        cnt_reg <= WRITE_HOLD_CYC;
                        state_reg <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    if (last_cyc) begin
                        ad_oe_reg <= 1'b0;
                        cnt_reg <= RECOVERY_CYC;
                        state_reg <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (last_cyc) begin
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ad_out = ad_out_reg;
    assign ad_oe = ad_oe_reg;
    assign ce_n = ce_n_reg;
    assign oe_n = oe_n_reg;
    assign we_n = we_n_reg;

    // checks on the pin sequencing and on the one-cycle apb ready pulse
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_read_end;
        $rose(oe_n_reg) && !ce_n_reg;
    endsequence

    sequence s_rmw_write;
        $fell(we_n_reg) && !ce_n_reg && ad_oe_reg;
    endsequence

    a_addr_before_select: assert property (
        $fell(ce_n_reg) |-> ad_oe_reg && $past(ad_oe_reg) && $stable(ad_out_reg))
        else $error("address not stable at select fall");

    // address stood on the lines through the whole cycle in which select fell
    a_addr_hold_time: assert property (
        $fell(ce_n_reg) |-> ad_oe_reg && (ad_out_reg == addr_reg))
        else $error("address not held after select fall");

    a_select_recovery: assert property (
        $rose(ce_n_reg) |=> ce_n_reg)
        else $error("select recovery too short");

    a_no_line_clash: assert property (
        !oe_n_reg |-> !ad_oe_reg && we_n_reg)
        else $error("host drives lines while outputs enabled");

    a_write_data_setup: assert property (
        $rose(we_n_reg) |-> !$past(we_n_reg, 2) && $stable(ad_out_reg) && ad_oe_reg)
        else $error("write data setup violated");

    // data still driven through the cycle after the strobe rose
    a_write_data_hold: assert property (
        $rose(we_n_reg) |-> ad_oe_reg && (ad_out_reg == wdata_reg))
        else $error("write data hold violated");

    a_rmw_write_after: assert property (
        s_read_end |-> ##[1:4] s_rmw_write)
        else $error("read-modify-write did not follow with a write");

    a_strobe_needs_select: assert property (
        !we_n_reg |-> !ce_n_reg && oe_n_reg)
        else $error("strobe low outside a selected cycle");

    a_read_wait_length: assert property (
        $fell(oe_n_reg) |-> !oe_n_reg [*4] ##1 oe_n_reg)
        else $error("read access window wrong length");

    a_apb_ready_pulse: assert property (
        pready_reg |=> !pready_reg)
        else $error("pready held longer than one cycle");
endmodule

/* File: tb/mbox_dev_model.sv */
`timescale 1ns/1ps
// behavioural dual-port mailbox memory; port 0 faces the host, port 1 the bench
module mbox_dev_model
    import mbox_host_pkg::*;
(
    input wire logic [1:0][8:0] host_ad,
    input wire logic [1:0] host_oe,
    input wire logic [1:0] ce_n,
    input wire logic [1:0] oe_n,
    input wire logic [1:0] we_n,
    output logic [1:0][8:0] ad,
    output logic [1:0] int_n
);
    logic [8:0] mem [512];
    logic [2:0] flags [2]; // ack, enable, request
    // no reset pin, so flags start cleared
    initial begin
        flags[0] = 3'h0;
        flags[1] = 3'h0;
    end
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [8:0] lat;
        logic [8:0] last = 9'h000;
        logic wr_act = 1'b0;
        realtime t_ce = 0.0;
        realtime t_oe = 0.0;
        logic [8:0] own_mbox;
        assign own_mbox = (p == 0) ? MBOX_X_ADDR : MBOX_Y_ADDR;
        // select falling latches the address, also when strobe is already low
        always @(negedge ce_n[p]) begin
            lat = ad[p];
            t_ce = $realtime;
        end
        always @(negedge oe_n[p]) t_oe = $realtime;
        // a write ends at the first rise of strobe or select
        always @(ce_n[p] or we_n[p]) begin
            if (wr_act && (ce_n[p] || we_n[p])) begin
                mem[lat] = ad[p];
                if (lat == own_mbox) begin
                    flags[p] = {ad[p][2:1], ad[p][0] & ~flags[1-p][2]};
                end
            end
            wr_act = !ce_n[p] && !we_n[p];
        end
        // resolve the shared lines; undriven lines toggle so stale data never passes
        always #5 begin
            if (host_oe[p]) begin
                ad[p] = host_ad[p];
            end else if (!ce_n[p] && !oe_n[p] && we_n[p]
                && $realtime >= t_ce + SELECT_ACCESS_NS
                && $realtime >= t_oe + OUTPUT_ACCESS_NS) begin
                ad[p] = mem[lat];
            end else begin
                ad[p] = ~last;
            end
            last = ad[p];
        end
        // interrupt low while the far side requests and this side is enabled and ready
        assign #50 int_n[p] = !(flags[1-p][0] && flags[p][1] && !flags[p][2]);
    end
endmodule

/* File: tb/mbox_host_tb_top.sv */
`timescale 1ns/1ps
// apb-driven checks of the mailbox host against the device model
module mbox_host_tb_top;
    import mbox_host_pkg::*;
    logic pclk;
    logic presetn;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [8:0] ad_out;
    logic ad_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [8:0] y_ad;
    logic y_oe;
    logic y_ce_n;
    logic y_we_n;
    logic [1:0][8:0] ad;
    logic [1:0] int_n;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;
    logic [8:0] addrs [3] = '{9'h001, 9'h100, 9'h1FE};
    logic [8:0] dats [3] = '{9'h1AA, 9'h055, 9'h100};

    mbox_host i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ad_in(ad[0]), .ad_out(ad_out),
        .ad_oe(ad_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .int_n(int_n[0]));
    mbox_dev_model i_dev (.host_ad({y_ad, ad_out}), .host_oe({y_oe, ad_oe}),
        .ce_n({y_ce_n, ce_n}), .oe_n({1'b1, oe_n}), .we_n({y_we_n, we_n}),
        .ad(ad), .int_n(int_n));

    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rq, output logic re);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one device cycle through the controller registers
    task automatic dev_op(input logic [1:0] op, input logic [8:0] a, input logic [8:0] d,
        output logic [31:0] rq);
        logic [31:0] s;
        logic se;
        apb(1'b1, ADDR_OFF, {23'h0, a}, s, se);
        apb(1'b1, WDATA_OFF, {23'h0, d}, s, se);
        apb(1'b1, CTRL_OFF, {29'h0, op, 1'b1}, s, se);
        do begin
            apb(1'b0, STATUS_OFF, 32'h0, s, se);
        end while (s[STAT_BUSY_BIT] !== 1'b0);
        check({31'h0, s[STAT_DONE_BIT]}, 32'h1);
        apb(1'b1, STATUS_OFF, 32'h2, s, se);
        apb(1'b0, RDATA_OFF, 32'h0, rq, se);
    endtask

    // write cycle on the far port, address first then data on the same lines
    task automatic y_write(input logic [8:0] a, input logic [8:0] d);
        @(posedge pclk);
        y_ad <= a;
        y_oe <= 1'b1;
        @(posedge pclk);
        y_ce_n <= 1'b0;
        @(posedge pclk);
        y_ad <= d;
        y_we_n <= 1'b0;
        repeat (2) @(posedge pclk);
        y_we_n <= 1'b1;
        y_ce_n <= 1'b1;
        @(posedge pclk);
        y_oe <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic irq_is(input logic exp);
        logic [31:0] s;
        logic se;
        repeat (4) @(posedge pclk);
        apb(1'b0, STATUS_OFF, 32'h0, s, se);
        check({31'h0, s[STAT_IRQ_BIT]}, {31'h0, exp});
    endtask

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        y_ad = 9'h000;
        y_oe = 1'b0;
        y_ce_n = 1'b1;
        y_we_n = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_OFF, 32'h0, q, e);
        check(q, {23'h0, ADDR_RESET});
        apb(1'b0, WDATA_OFF, 32'h0, q, e);
        check(q, {23'h0, DATA_RESET});
        apb(1'b0, STATUS_OFF, 32'h0, q, e);
        check(q, 32'h0);
        test_end("reset");
        apb(1'b0, 12'h020, 32'h0, q, e);
        check(q, 32'h0);
        check({31'h0, e}, 32'h1);
        test_end("unmapped");
        for (int i = 0; i < 3; i++) begin
            dev_op(OP_WRITE, addrs[i], dats[i], q);
            dev_op(OP_READ, addrs[i], 9'h000, q);
            check(q, {23'h0, dats[i]});
        end
        test_end("words");
        dev_op(OP_RMW, 9'h100, 9'h0C3, q);
        check(q, 32'h055);
        dev_op(OP_READ, 9'h100, 9'h000, q);
        check(q, 32'h0C3);
        test_end("rmw");
        y_write(9'h055, 9'h123);
        dev_op(OP_READ, 9'h055, 9'h000, q);
        check(q, 32'h123);
        test_end("far port");
        y_write(MBOX_X_ADDR, 9'h007);
        dev_op(OP_READ, MBOX_X_ADDR, 9'h000, q);
        check(q, 32'h007);
        y_write(MBOX_Y_ADDR, 9'h001);
        irq_is(1'b0);
        dev_op(OP_WRITE, MBOX_X_ADDR, 9'h1FA, q);
        irq_is(1'b1);
        dev_op(OP_WRITE, MBOX_X_ADDR, 9'h006, q);
        irq_is(1'b0);
        y_write(MBOX_Y_ADDR, 9'h000);
        dev_op(OP_WRITE, MBOX_X_ADDR, 9'h002, q);
        irq_is(1'b0);
        y_write(MBOX_Y_ADDR, 9'h001);
        irq_is(1'b1);
        dev_op(OP_WRITE, MBOX_X_ADDR, 9'h000, q);
        irq_is(1'b0);
        test_end("interrupt");
        final_report();
    end
endmodule
